// >>> logic/phr_defines.vh
// Purpose: Constants for the pin function and protection block
// Assumes: Byte addressed Avalon-MM slave, 32-bit data
// Notes: Offsets are byte addresses
`ifndef PHR_DEFINES_VH
`define PHR_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define PHR_OFS_STATUS 4'h0
`define PHR_OFS_FUNC 4'h4
`define PHR_OFS_READ 4'h8
`define PHR_OFS_PINSTAT 4'hc

// ****************************************
// Status register fields
// ****************************************
`define PHR_ST_SWD 7
`define PHR_ST_QE 6
`define PHR_ST_BP_HI 5
`define PHR_ST_BP_LO 2
`define PHR_ST_RST 8'h00

// ****************************************
// Function and read register fields
// ****************************************
`define PHR_FN_RSTDIS 0
`define PHR_FN_RST 8'h00
`define PHR_RD_PRSEL 7
`define PHR_RD_RST 8'h00

// ****************************************
// Pin status fields
// ****************************************
`define PHR_PS_PAUSED 0
`define PHR_PS_HWRST 1
`define PHR_PS_SEL 2
`define PHR_PS_WP 3
`define PHR_PS_MODE_HI 5
`define PHR_PS_MODE_LO 4
`define PHR_PS_REJ 8

// ****************************************
// Shared pin modes
// ****************************************
`define PHR_MODE_PAUSE 2'h0
`define PHR_MODE_RESET 2'h1
`define PHR_MODE_QUAD 2'h2

// ****************************************
// Pin sampler
// ****************************************
`define PHR_NPIN 5
`define PHR_PIN_SCLK 4
`define PHR_PIN_SELN 3
`define PHR_PIN_WP 2
`define PHR_PIN_HOLD 1
`define PHR_PIN_RSTN 0
`define PHR_PIN_IDLE 5'h0f

`endif

// >>> logic/phr_pin_control.v
// Purpose: Pin function, status write protection, pause and hardware reset
// Assumes: Pins are asynchronous to clk_in and sampled through three flops
// Notes: Serial clock edges are found by oversampling the sampled clock pin
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "phr_defines.vh"

module phr_pin_control #(
    parameter HAS_RESET_PIN = 1
) (
    // Clock and reset
    input wire clk_in,
    input wire resetn_in,
    // Avalon-MM slave
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    // Serial pins
    input wire sclk_in,
    input wire sel_n_in,
    input wire wp_io2_in,
    input wire hold_io3_in,
    input wire reset_n_in,
    output reg so_oe_out,
    output reg io2_out,
    output reg io2_oe_out,
    output reg io3_out,
    output reg io3_oe_out,
    // Core side
    input wire core_so_oe_in,
    input wire core_io2_in,
    input wire core_io2_oe_in,
    input wire core_io3_in,
    input wire core_io3_oe_in,
    input wire core_busy_in,
    output reg sclk_rise_out,
    output reg sclk_fall_out,
    output reg quad_line_2_out,
    output reg quad_line_3_out,
    output reg selected_out,
    output reg paused_out,
    output reg hw_reset_out,
    output reg reset_lost_out
);

    // ****************************************
    // Pin sampling
    // ****************************************
    wire [`PHR_NPIN-1:0] pin_raw;
    reg [`PHR_NPIN-1:0] pin_s1_r;
    reg [`PHR_NPIN-1:0] pin_s2_r;
    reg [`PHR_NPIN-1:0] pin_s3_r;
    reg [`PHR_NPIN-1:0] pin_r;
    reg sclk_d_r;

    assign pin_raw = {sclk_in, sel_n_in, wp_io2_in, hold_io3_in, reset_n_in};

    // Idle pin levels, so no false select or clock edge follows reset
    localparam [`PHR_NPIN-1:0] PIN_IDLE = `PHR_PIN_IDLE;

    genvar gi;
    generate
        for (gi = 0; gi < `PHR_NPIN; gi = gi + 1)
        begin : g_pin
            // Level counts once stages two and three agree
            always @(posedge clk_in)
            begin
                if (!resetn_in)
                begin
                    pin_s1_r[gi] <= PIN_IDLE[gi];
                    pin_s2_r[gi] <= PIN_IDLE[gi];
                    pin_s3_r[gi] <= PIN_IDLE[gi];
                    pin_r[gi] <= PIN_IDLE[gi];
                end
                else
                begin
                    pin_s1_r[gi] <= pin_raw[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                    pin_s3_r[gi] <= pin_s2_r[gi];
                    if (pin_s2_r[gi] == pin_s3_r[gi])
                    begin
                        pin_r[gi] <= pin_s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] status_r;
    reg [7:0] func_r;
    reg [7:0] rdreg_r;
    reg reject_r;
    reg [31:0] rdata_nxt;
    wire req;
    wire wr_take;
    wire wr_status;
    wire wr_func;
    wire wr_read;
    wire wr_pinstat;
    wire status_locked;
    wire rej_set;
    wire quad_enable;
    wire status_write_disable;
    wire pause_reset_select;
    wire rst_pin_en;
    reg [1:0] mode_nxt;

    assign quad_enable = status_r[`PHR_ST_QE];
    assign status_write_disable = status_r[`PHR_ST_SWD];
    assign pause_reset_select = rdreg_r[`PHR_RD_PRSEL];
    assign rst_pin_en = (HAS_RESET_PIN != 0) && !func_r[`PHR_FN_RSTDIS];

    assign req = (avs_read_in || avs_write_in) && avs_waitrequest_out;
    // Writes land at the edge where the master sees waitrequest low
    assign wr_take = avs_write_in && !avs_waitrequest_out;

    // Register write decode
    assign wr_status = wr_take && (avs_address_in == `PHR_OFS_STATUS);
    assign wr_func = wr_take && (avs_address_in == `PHR_OFS_FUNC);
    assign wr_read = wr_take && (avs_address_in == `PHR_OFS_READ);
    assign wr_pinstat = wr_take && (avs_address_in == `PHR_OFS_PINSTAT);
    // protect lock, no lock when clear, protect ignored in quad
    assign status_locked = status_write_disable && !pin_r[`PHR_PIN_WP] && !quad_enable;
    assign rej_set = wr_status && status_locked;

    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        case (avs_address_in)
            `PHR_OFS_STATUS:
            begin
                rdata_nxt[7:0] = status_r;
            end
            `PHR_OFS_FUNC:
            begin
                rdata_nxt[7:0] = func_r;
            end
            `PHR_OFS_READ:
            begin
                rdata_nxt[7:0] = rdreg_r;
            end
            `PHR_OFS_PINSTAT:
            begin
                rdata_nxt[`PHR_PS_PAUSED] = paused_out;
                rdata_nxt[`PHR_PS_HWRST] = hw_reset_out;
                rdata_nxt[`PHR_PS_SEL] = selected_out;
                rdata_nxt[`PHR_PS_WP] = pin_r[`PHR_PIN_WP];
                rdata_nxt[`PHR_PS_MODE_HI:`PHR_PS_MODE_LO] = mode_nxt;
                rdata_nxt[`PHR_PS_REJ] = reject_r;
            end
            default:
            begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Request taken while waitrequest high, answered one cycle later
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end
        else if (req)
        begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= avs_read_in ? rdata_nxt : 32'h0000_0000;
        end
        else
        begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            status_r <= `PHR_ST_RST;
            func_r <= `PHR_FN_RST;
            rdreg_r <= `PHR_RD_RST;
            reject_r <= 1'b0;
        end
        else
        begin
            if (wr_status && !status_locked)
            begin
                status_r[`PHR_ST_SWD:`PHR_ST_BP_LO] <=
                    avs_writedata_in[`PHR_ST_SWD:`PHR_ST_BP_LO];
            end
            if (wr_func)
            begin
                func_r[`PHR_FN_RSTDIS] <= avs_writedata_in[`PHR_FN_RSTDIS];
            end
            if (wr_read)
            begin
                rdreg_r[`PHR_RD_PRSEL] <= avs_writedata_in[`PHR_RD_PRSEL];
            end
            // Sticky reject flag, set wins over write-one clear
            if (rej_set)
            begin
                reject_r <= 1'b1;
            end
            else if (wr_pinstat && avs_writedata_in[`PHR_PS_REJ])
            begin
                // Write one to clear
                reject_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // Shared pin function
    // ****************************************
    always @*
    begin
        if (quad_enable)
        begin
            mode_nxt = `PHR_MODE_QUAD;
        end
        else if (rst_pin_en)
        begin
            mode_nxt = `PHR_MODE_PAUSE;
        end
        else if (pause_reset_select)
        begin
            mode_nxt = `PHR_MODE_RESET;
        end
        else
        begin
            mode_nxt = `PHR_MODE_PAUSE;
        end
    end

    // ****************************************
    // Pause, reset and select
    // ****************************************
    wire sel_now;
    wire hwrst_now;
    wire pause_now;
    wire sclk_rise;
    wire sclk_fall;
    wire run;

    assign sel_now = !pin_r[`PHR_PIN_SELN];
    // reset from dedicated or shared pin
    assign hwrst_now = (rst_pin_en && !pin_r[`PHR_PIN_RSTN]) ||
                       ((mode_nxt == `PHR_MODE_RESET) && !pin_r[`PHR_PIN_HOLD]);
    assign pause_now = (mode_nxt == `PHR_MODE_PAUSE) && !pin_r[`PHR_PIN_HOLD] && sel_now;
    assign run = sel_now && !pause_now && !hwrst_now;
    assign sclk_rise = pin_r[`PHR_PIN_SCLK] && !sclk_d_r;
    assign sclk_fall = !pin_r[`PHR_PIN_SCLK] && sclk_d_r;

    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            sclk_d_r <= 1'b0;
            sclk_rise_out <= 1'b0;
            sclk_fall_out <= 1'b0;
            selected_out <= 1'b0;
            paused_out <= 1'b0;
            hw_reset_out <= 1'b0;
            reset_lost_out <= 1'b0;
        end
        else
        begin
            sclk_d_r <= pin_r[`PHR_PIN_SCLK];
            // edges dropped while paused, resume keeps progress
            sclk_rise_out <= sclk_rise && run;
            sclk_fall_out <= sclk_fall && run;
            selected_out <= sel_now && !hwrst_now;
            paused_out <= pause_now && !hwrst_now;
            hw_reset_out <= hwrst_now;
            // flag reset hitting a busy core
            reset_lost_out <= hwrst_now && core_busy_in;
        end
    end

    // ****************************************
    // Output drivers
    // ****************************************
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            so_oe_out <= 1'b0;
            io2_out <= 1'b0;
            io2_oe_out <= 1'b0;
            io3_out <= 1'b0;
            io3_oe_out <= 1'b0;
            quad_line_2_out <= 1'b0;
            quad_line_3_out <= 1'b0;
        end
        else
        begin
            so_oe_out <= core_so_oe_in && run;
            // Data copies run free; the enables decide what reaches the pins
            io2_out <= core_io2_in;
            io3_out <= core_io3_in;
            // quad lines drive only in quad mode
            io2_oe_out <= core_io2_oe_in && quad_enable && run;
            io3_oe_out <= core_io3_oe_in && quad_enable && run;
            // input lines frozen while not running
            if (run && quad_enable)
            begin
                quad_line_2_out <= pin_r[`PHR_PIN_WP];
                quad_line_3_out <= pin_r[`PHR_PIN_HOLD];
            end
        end
    end

endmodule // phr_pin_control

// >>> verification/phr_pin_control_assertions.sv
// Purpose: Port level checks of the pin function block
// Assumes: Sees only the ports of phr_pin_control
// Notes: Bound from the tb top file
`timescale 1ns/1ps

module phr_pin_control_assertions (
    input wire clk_in,
    input wire resetn_in,
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire sel_n_in,
    input wire so_oe_out,
    input wire io2_oe_out,
    input wire io3_oe_out,
    input wire sclk_rise_out,
    input wire sclk_fall_out,
    input wire selected_out,
    input wire paused_out,
    input wire hw_reset_out
);
    reg [3:0] idle_r;

    // Cycles the select pin has stayed high
    always @(posedge clk_in)
    begin
        if (!resetn_in || !sel_n_in)
            idle_r <= 4'h0;
        else if (idle_r != 4'hf)
            idle_r <= idle_r + 4'h1;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    chk_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("bus request not answered");
    chk_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    chk_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
        && avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h0)
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (avs_read_in && !avs_waitrequest_out
        |-> avs_readdata_out[31:9] == 23'h0) else $error("upper read bits set");
    chk_so_gate: assert property (
        so_oe_out |-> selected_out && !paused_out && !hw_reset_out)
        else $error("serial out enabled while not running");
    chk_quad_gate: assert property (
        io2_oe_out || io3_oe_out |-> selected_out && !paused_out && !hw_reset_out)
        else $error("quad line driven while not running");
    chk_edge_gate: assert property (
        sclk_rise_out || sclk_fall_out |-> selected_out && !paused_out && !hw_reset_out)
        else $error("serial clock edge passed while not running");
    chk_edge_single: assert property (
        sclk_rise_out |=> !sclk_rise_out && !sclk_fall_out) else $error("edge pulse too long");
    chk_reset_quiet: assert property (
        hw_reset_out |-> !selected_out && !paused_out) else $error("active during reset mode");
    chk_sel_idle: assert property (
        idle_r >= 4'h8 |-> !selected_out && !paused_out) else $error("active while deselected");
    chk_reset_state: assert property (disable iff (1'b0)
        !resetn_in |=> avs_waitrequest_out && !so_oe_out && !hw_reset_out)
        else $error("wrong state after reset");
endmodule // phr_pin_control_assertions

// >>> verification/phr_host_model.sv
// Purpose: Serial bus host driving the flash pins
// Assumes: Pins are asynchronous to the block clock
// Notes: Serial clock runs only inside frames, period 200 ns
`timescale 1ns/1ps

module phr_host_model (
    output reg sclk_out,
    output reg sel_n_out,
    output reg wp_out,
    output reg hold_n_out,
    output reg reset_n_out
);
    initial
    begin
        sclk_out = 1'b0;
        sel_n_out = 1'b1;
        wp_out = 1'b1;
        hold_n_out = 1'b1;
        reset_n_out = 1'b1;
    end

    task clocks(input integer n);
        repeat (n)
        begin
            #100 sclk_out = 1'b1;
            #100 sclk_out = 1'b0;
        end
    endtask

    task select(input v);
        #200 sel_n_out = !v;
        #400;
    endtask

    task protect(input v);
        #200 wp_out = v;
        #400;
    endtask

    // shared line raised again to resume; low only on command
    task pause(input v);
        #200 hold_n_out = !v;
        #400;
    endtask

    // dedicated reset pin, driven low only on command
    task reset_pin(input v);
        #200 reset_n_out = !v;
        #400;
    endtask
endmodule // phr_host_model

// >>> verification/tb.sv
// Purpose: Self-checking bench of the pin function block
// Assumes: Dedicated reset pin present
// Notes: Random data from a fixed seed
`timescale 1ns/1ps

module tb;
    reg clk_in = 1'b0;
    reg resetn_in = 1'b0;
    reg [3:0] avs_address_in = 4'h0;
    reg avs_read_in = 1'b0;
    reg avs_write_in = 1'b0;
    reg [31:0] avs_writedata_in = 32'h0;
    reg core_io2_in = 1'b0;
    reg core_io3_in = 1'b0;
    reg core_busy_in = 1'b0;
    reg core_so_oe_in = 1'b1;
    reg core_io2_oe_in = 1'b1;
    reg core_io3_oe_in = 1'b1;
    wire [31:0] avs_readdata_out;
    wire avs_waitrequest_out, so_oe_out, sclk_rise_out, paused_out, hw_reset_out, reset_lost_out;
    wire io2_out, io2_oe_out, io3_out, io3_oe_out, sclk_fall_out, selected_out;
    wire quad_line_2_out, quad_line_3_out;
    wire sclk, sel_n, wp, hold_n, rst_n;
    integer seed = 55012;
    integer miscompares = 0;
    integer check_count = 0;
    integer nrise = 0;
    integer nfall = 0;
    integer k;
    reg [1:0] io_d = 2'h0;
    reg io_v = 1'b0;
    reg [31:0] q, rnd;
    reg [7:0] st, d;
    reg p, r;

    always #12.5 clk_in = ~clk_in;

    always @(posedge clk_in)
    begin
        rnd = $random(seed);
        core_io2_in <= rnd[0];
        core_io3_in <= rnd[1];
        if (sclk_rise_out === 1'b1)
            nrise = nrise + 1;
        if (sclk_fall_out === 1'b1)
            nfall = nfall + 1;
        if (io_v)
            check({30'h0, io3_out, io2_out}, {30'h0, io_d});
        io_v <= resetn_in;
        io_d <= {core_io3_in, core_io2_in};
    end

    phr_pin_control DUT (.clk_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .sclk_in(sclk),
        .sel_n_in(sel_n), .wp_io2_in(wp), .hold_io3_in(hold_n), .reset_n_in(rst_n),
        .so_oe_out, .io2_out, .io2_oe_out, .io3_out, .io3_oe_out,
        .core_so_oe_in, .core_io2_in, .core_io2_oe_in, .core_io3_in,
        .core_io3_oe_in, .core_busy_in, .sclk_rise_out, .sclk_fall_out,
        .quad_line_2_out, .quad_line_3_out, .selected_out, .paused_out, .hw_reset_out,
        .reset_lost_out);

    phr_host_model host (.sclk_out(sclk), .sel_n_out(sel_n), .wp_out(wp), .hold_n_out(hold_n),
        .reset_n_out(rst_n));

    task check(input [31:0] got, input [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task bus(input w, input [3:0] a, input [31:0] dd);
        begin
            @(posedge clk_in);
            avs_address_in <= a;
            avs_writedata_in <= dd;
            avs_write_in <= w;
            avs_read_in <= !w;
            @(posedge clk_in);
            while (avs_waitrequest_out !== 1'b0)
                @(posedge clk_in);
            q = avs_readdata_out;
            avs_write_in <= 1'b0;
            avs_read_in <= 1'b0;
        end
    endtask

    function [7:0] exp_st(input [7:0] cur, input [7:0] w, input pin);
        exp_st = (cur[7] && !pin && !cur[6]) ? cur : (w & 8'hfc);
    endfunction

    task test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        miscompares = miscompares + 1;
        test_done;
    end

    initial
    begin
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        for (k = 0; k < 12; k = k + 2)
        begin
            bus(1'b0, k[3:0], 32'h0);
            check(q, 32'h0);
        end
        host.select(1'b1);
        check(so_oe_out, 32'h1);
        check(selected_out, 32'h1);
        host.clocks(3);
        host.pause(1'b1);
        check(paused_out, 32'h1);
        check(so_oe_out, 32'h0);
        host.clocks(2);
        host.pause(1'b0);
        check(paused_out, 32'h0);
        core_so_oe_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        check(so_oe_out, 32'h0);
        core_so_oe_in <= 1'b1;
        host.clocks(2);
        host.select(1'b0);
        check(nrise, 32'd5);
        check(nfall, 32'd5);
        check(selected_out, 32'h0);
        for (k = 0; k < 8; k = k + 1)
        begin
            bus(1'b1, 4'h0, {25'h0, k[2], 6'h0});
            bus(1'b1, 4'h4, {31'h0, k[1]});
            bus(1'b1, 4'h8, {24'h0, k[0], 7'h0});
            bus(1'b0, 4'hc, 32'h0);
            check(q[5:4], k[2] ? 2 : (k[1] & k[0]));
        end
        st = 8'h40;
        for (k = 0; k < 16; k = k + 1)
        begin
            rnd = $random(seed);
            p = (k < 4) ? k[0] : rnd[0];
            d = (k < 2) ? 8'h80 : rnd[15:8];
            host.protect(p);
            r = st[7] && !p && !st[6];
            bus(1'b1, 4'h0, {24'h0, d});
            st = exp_st(st, d, p);
            bus(1'b0, 4'h0, 32'h0);
            check(q, {24'h0, st});
            bus(1'b0, 4'hc, 32'h0);
            check(q[8], r);
            bus(1'b1, 4'hc, 32'h100);
        end
        host.protect(1'b1);
        bus(1'b1, 4'h0, 32'h40);
        host.select(1'b1);
        host.pause(1'b1);
        host.protect(1'b0);
        check(paused_out, 32'h0);
        check(quad_line_3_out, 32'h0);
        check(quad_line_2_out, 32'h0);
        check(io3_oe_out, 32'h1);
        core_io2_oe_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        check(io2_oe_out, 32'h0);
        core_io2_oe_in <= 1'b1;
        host.pause(1'b0);
        host.protect(1'b1);
        check(quad_line_3_out, 32'h1);
        check(quad_line_2_out, 32'h1);
        check(io2_oe_out, 32'h1);
        host.select(1'b0);
        host.protect(1'b0);
        check(quad_line_2_out, 32'h1);
        check(io2_oe_out, 32'h0);
        bus(1'b1, 4'h0, 32'h0);
        bus(1'b1, 4'h4, 32'h0);
        bus(1'b1, 4'h8, 32'h80);
        host.reset_pin(1'b1);
        check(hw_reset_out, 32'h1);
        host.reset_pin(1'b0);
        host.pause(1'b1);
        check(hw_reset_out, 32'h0);
        host.pause(1'b0);
        bus(1'b1, 4'h4, 32'h1);
        host.reset_pin(1'b1);
        check(hw_reset_out, 32'h0);
        host.reset_pin(1'b0);
        core_busy_in <= 1'b1;
        host.pause(1'b1);
        check(hw_reset_out, 32'h1);
        check(reset_lost_out, 32'h1);
        host.pause(1'b0);
        check(hw_reset_out, 32'h0);
        test_done;
    end
endmodule // tb

bind phr_pin_control phr_pin_control_assertions u_chk (.clk_in, .resetn_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .sel_n_in, .so_oe_out,
    .io2_oe_out, .io3_oe_out, .sclk_rise_out, .sclk_fall_out, .selected_out, .paused_out,
    .hw_reset_out);
